// *** chg_mode_pkg.sv ***
// Function
// - Enable plus unregulated select starts fast charge and sets active flag
// - Fast charge uses same thresholds; pulse current follows unregulated select
// - After end-of-charge, resume when voltage below resume threshold
// - First threshold trip with pulse clear enters voltage mode, sets flag
// - Voltage mode regulates to anode-selected target; charger stays enabled
// - Voltage mode current at or below termination ends charge
// - End-of-charge wins over no-battery when both occur
// - Below resume threshold after end: clear end, resume voltage mode
// - Voltage-phase flag stays set while end-of-charge is set
// - Debounce resume one measurement cycle, then need pulses in next
// - Voltage mode current above constant current clears phase flag
// - End-of-charge entered only with auto termination bit set
// - Threshold trip with pulse select enters pulse mode, minimum off-time
// - Pulse stays on until above threshold, then minimum off-time
// - Overvoltage lockout disables charging immediately
// - On-pulses regulated when select zero, fully on when one
// - Off-interval longer than maximum off-time terminates, sets end
// - On-pulse longer than maximum off-time returns to current mode
// - Pulse mode: below resume threshold after end resumes pulse charging
// - No sense current sets absent and phase flags; current clears both
// - Presence-detect disable suppresses battery presence indication
// - Battery-less regulation with adapter and enable, unless disabled
// - Lithium threshold chosen by anode bit; nickel uses higher target
package chg_mode_pkg;
    localparam logic [31:0] ADDR_CTRL   = 32'h0000_0000;
    localparam logic [31:0] ADDR_TIMING = 32'h0000_0004;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0008;
    localparam int CTRL_ENABLE   = 0;
    localparam int CTRL_UNREG    = 1;
    localparam int CTRL_PULSE    = 2;
    localparam int CTRL_ANODE    = 3;
    localparam int CTRL_CHEM     = 4;
    localparam int CTRL_AUTOTERM = 5;
    localparam int CTRL_PDDIS    = 6;
    localparam int CTRL_BLDIS    = 7;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [5:0]  TIMING_RESET = 6'h00;
    localparam logic [1:0]  MAXOFF_NONE  = 2'h3;
    // Pulse time unit in clocks; units of 1 ms at 125 MHz
    localparam int    PULSE_UNIT_US = 1000;
    localparam int    CLK_MHZ       = 125;
    localparam int    UNIT_CYCLES   = PULSE_UNIT_US * CLK_MHZ;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {
        ST_IDLE, ST_CURRENT, ST_VOLTAGE, ST_PULSE_ON, ST_PULSE_OFF, ST_EOC
    } mode_e;

    typedef struct packed {
        logic over_term;   // Above termination threshold
        logic below_resume;
        logic over_ovlo;
        logic i_le_term;
        logic i_gt_cc;
        logic i_sensed;
        logic meas_strobe;
        logic adapter;
    } sense_s;

    typedef struct packed {
        logic regulate_cc;   // Current regulated to constant current
        logic full_on;
        logic regulate_v;
        logic [1:0] v_target;  // 0: 4.1 V, 1: 4.2 V, 2: nickel
    } drive_s;
endpackage : chg_mode_pkg

// *** chg_mode_ctrl.sv ***
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module chg_mode_ctrl
    import chg_mode_pkg::*;
#(
    parameter int UNIT_CLKS = UNIT_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire sense_s      sense,
    output drive_s           drive,
    output logic             charger_on
);
    logic       rst_meta;
    logic       rst_sync;
    sense_s     s_meta;
    sense_s     s;
    logic [7:0] ctrl;
    logic [5:0] timing;
    mode_e      mode;
    mode_e      next_mode;
    logic       charger_active_flag;
    logic       voltage_phase_flag;
    logic       battery_absent_flag;
    logic       eoc_flag;
    logic       next_eoc;
    logic       next_vpf;
    logic [19:0] unit_cnt;
    logic [7:0]  tick_cnt;
    logic        unit_tick;
    logic [1:0]  resume_stage;
    logic        resume_seen;
    logic        resume_clear;
    logic        aw_held;
    logic        w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    wire charger_enable_bit  = ctrl[CTRL_ENABLE];
    wire unreg_sel           = ctrl[CTRL_UNREG];
    wire pulse_sel           = ctrl[CTRL_PULSE];
    wire anode_type_select   = ctrl[CTRL_ANODE];
    wire chemistry_select    = ctrl[CTRL_CHEM];
    wire auto_termination_bit = ctrl[CTRL_AUTOTERM];
    wire presence_detect_disable = ctrl[CTRL_PDDIS];
    wire batteryless_disable = ctrl[CTRL_BLDIS];
    wire [1:0] min_on_time_field  = timing[1:0];
    wire [1:0] min_off_time_field = timing[3:2];
    wire [1:0] max_off_time_field = timing[5:4];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_sync);

    // Pulse field code to time units: 1, 2, 4, 8
    function automatic logic [7:0] units(input logic [1:0] code);
        units = 8'h01 << code;
    endfunction : units

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            s_meta <= '0;
            s      <= '0;
        end else begin
            s_meta <= sense;
            s      <= s_meta;
        end
    end

    // Register write path
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= '0;
            w_data       <= '0;
            w_strb       <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            ctrl         <= CTRL_RESET;
            timing       <= TIMING_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OKAY;
                if (aw_addr == ADDR_CTRL && w_strb[0])
                    ctrl <= w_data[7:0];
                else if (aw_addr == ADDR_TIMING && w_strb[0])
                    timing <= w_data[5:0];
                else if (aw_addr != ADDR_CTRL && aw_addr != ADDR_TIMING)
                    s_axi_bresp <= RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire wr_done = aw_held && w_held && !s_axi_bvalid;
    wire bv_next = wr_done || (s_axi_bvalid && !s_axi_bready);
    wire rv_next = (s_axi_arvalid && s_axi_arready)
                   || (s_axi_rvalid && !s_axi_rready);

    // Ready from next-cycle state, so each output leaves a flop
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= !bv_next && !aw_held
                             && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !bv_next && !w_held
                             && !(s_axi_wvalid && s_axi_wready);
            s_axi_arready <= !rv_next;
        end
    end

    // Register read path
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL:   s_axi_rdata <= {24'h00_0000, ctrl};
                ADDR_TIMING: s_axi_rdata <= {26'h000_0000, timing};
                ADDR_STATUS: s_axi_rdata <= {28'h000_0000, eoc_flag,
                    battery_absent_flag, voltage_phase_flag,
                    charger_active_flag};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Pulse time base and pulse-length counter
    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            unit_cnt  <= '0;
            unit_tick <= 1'b0;
        end else begin
            unit_tick <= (unit_cnt == 20'(UNIT_CLKS - 1));
            unit_cnt  <= (unit_cnt == 20'(UNIT_CLKS - 1)) ? '0
                       : unit_cnt + 20'h0_0001;
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync)
            tick_cnt <= '0;
        else if (mode != next_mode)
            tick_cnt <= '0;
        else if (unit_tick && tick_cnt != 8'hFF)
            tick_cnt <= tick_cnt + 8'h01;
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            resume_stage <= '0;
            resume_seen  <= 1'b0;
            resume_clear <= 1'b0;
        end else if (mode != ST_EOC) begin
            resume_stage <= '0;
            resume_seen  <= 1'b0;
            resume_clear <= 1'b0;
        end else begin
            if (s.meas_strobe) begin
                resume_seen <= 1'b0;
                if (resume_stage == 2'h0 && resume_seen)
                    resume_stage <= 2'h1;
                else if (resume_stage == 2'h1)
                    resume_stage <= resume_seen ? 2'h2 : 2'h0;
            end
            // Pulse on the strobe cycle counts for the new window
            if (s.below_resume)
                resume_seen <= 1'b1;
            resume_clear <= (resume_stage == 2'h2);
        end
    end

    wire max_off_on = max_off_time_field != MAXOFF_NONE;
    wire max_off_hit = max_off_on
        && tick_cnt > units(max_off_time_field);

    always_comb begin
        next_mode = mode;
        next_eoc  = eoc_flag;
        next_vpf  = voltage_phase_flag;
        case (mode)
            ST_IDLE: begin
                if (charger_enable_bit)
                    next_mode = ST_CURRENT;
            end
            ST_CURRENT: begin
                if (s.over_term) begin
                    next_vpf  = 1'b1;
                    next_mode = pulse_sel ? ST_PULSE_OFF : ST_VOLTAGE;
                end
            end
            ST_VOLTAGE: begin
                if (s.i_le_term && auto_termination_bit) begin
                    next_mode = ST_EOC;
                    next_eoc  = 1'b1;
                end else if (s.i_gt_cc) begin
                    next_vpf  = 1'b0;
                    next_mode = ST_CURRENT;
                end
            end
            ST_PULSE_ON: begin
                // hold past minimum on-time until above
                if (tick_cnt >= units(min_on_time_field) && s.over_term)
                    next_mode = ST_PULSE_OFF;
                else if (max_off_hit) begin
                    next_vpf  = 1'b0;
                    next_mode = ST_CURRENT;
                end
            end
            ST_PULSE_OFF: begin
                if (max_off_hit && auto_termination_bit) begin
                    next_mode = ST_EOC;
                    next_eoc  = 1'b1;
                end else if (tick_cnt >= units(min_off_time_field)
                             && !s.over_term)
                    next_mode = ST_PULSE_ON;
            end
            ST_EOC: begin
                if (resume_clear) begin
                    next_eoc  = 1'b0;
                    next_mode = pulse_sel ? ST_PULSE_ON : ST_VOLTAGE;
                end
            end
            default: next_mode = ST_IDLE;
        endcase
        if (!charger_enable_bit) begin
            next_mode = ST_IDLE;
            next_eoc  = 1'b0;
            next_vpf  = 1'b0;
        end
        if (next_eoc)
            next_vpf = 1'b1;
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            mode                <= ST_IDLE;
            eoc_flag            <= 1'b0;
            charger_active_flag <= 1'b0;
        end else begin
            mode                <= next_mode;
            eoc_flag            <= next_eoc;
            charger_active_flag <= next_mode != ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            voltage_phase_flag  <= 1'b0;
            battery_absent_flag <= 1'b0;
        end else begin
            voltage_phase_flag <= next_vpf;
            if (next_mode == ST_IDLE || presence_detect_disable) begin
                battery_absent_flag <= 1'b0;
            end else if (!next_eoc && s.meas_strobe) begin
                // Clear only when current returns, not on every sample
                if (!s.i_sensed) begin
                    battery_absent_flag <= 1'b1;
                    voltage_phase_flag  <= 1'b1;
                end else if (battery_absent_flag) begin
                    battery_absent_flag <= 1'b0;
                    voltage_phase_flag  <= 1'b0;
                end
            end
        end
    end

    wire in_v = mode == ST_VOLTAGE;
    wire in_on = mode == ST_PULSE_ON || mode == ST_CURRENT;
    wire bl_reg = battery_absent_flag && s.adapter && !batteryless_disable;

    always_ff @(posedge clk or negedge rst_sync) begin
        if (!rst_sync) begin
            drive      <= '0;
            charger_on <= 1'b0;
        end else begin
            charger_on <= !s.over_ovlo && (in_v || in_on || bl_reg);
            drive.regulate_cc <= in_on && !unreg_sel && !s.over_ovlo;
            drive.full_on     <= in_on && unreg_sel && !s.over_ovlo;
            drive.regulate_v  <= (in_v || bl_reg) && !s.over_ovlo;
            drive.v_target    <= chemistry_select ? 2'h2
                               : {1'b0, anode_type_select};
        end
    end

    a_ovlo_cut: assert property (s.over_ovlo |=> !charger_on)
        else $error("charger on in lockout");
    a_eoc_auto: assert property (
        $rose(eoc_flag) |-> $past(auto_termination_bit))
        else $error("end entered without auto termination");
    a_vpf_eoc: assert property (eoc_flag |-> voltage_phase_flag)
        else $error("phase flag dropped");
    a_volt_entry: assert property (
        (mode == ST_CURRENT && s.over_term && !pulse_sel
         && charger_enable_bit) |=> mode == ST_VOLTAGE)
        else $error("voltage mode not entered");
    a_pulse_entry: assert property (
        (mode == ST_CURRENT && s.over_term && pulse_sel
         && charger_enable_bit) |=> mode == ST_PULSE_OFF)
        else $error("pulse mode not entered");
    a_active_start: assert property (
        (mode == ST_IDLE && charger_enable_bit) |=> charger_active_flag)
        else $error("active flag not set");
    a_full_on: assert property (
        (in_on && !s.over_ovlo) |=> drive.full_on == $past(unreg_sel)
        && drive.regulate_cc == !$past(unreg_sel))
        else $error("on-pulse drive wrong");
    a_term_cur: assert property (
        (in_v && s.i_le_term && auto_termination_bit && charger_enable_bit)
        |=> eoc_flag) else $error("end-of-charge missed");
    a_cc_return: assert property (
        (in_v && s.i_gt_cc && !s.i_le_term && charger_enable_bit)
        |=> mode == ST_CURRENT) else $error("voltage mode not left");
    a_absent_set: assert property (
        (s.meas_strobe && !s.i_sensed && next_mode != ST_IDLE
         && !presence_detect_disable && !next_eoc)
        |=> battery_absent_flag && voltage_phase_flag)
        else $error("absence not flagged");
endmodule : chg_mode_ctrl

// *** axi_bus.sv ***
`timescale 1ns/1ps
interface axi_bus (
    input wire logic clk
);
    logic [31:0] awaddr, wdata, araddr, rdata, rd_q;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, bresp_q, rresp_q;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic        aw_hs, w_hs, ar_hs, b_hs, r_hs;

    // Handshakes latched at the edge so the master never races the slave
    always_ff @(posedge clk) begin
        aw_hs   <= awvalid && awready;
        w_hs    <= wvalid && wready;
        ar_hs   <= arvalid && arready;
        b_hs    <= bvalid && bready;
        r_hs    <= rvalid && rready;
        bresp_q <= bresp;
        rresp_q <= rresp;
        rd_q    <= rdata;
    end
endinterface : axi_bus

// *** axi_host.sv ***
`timescale 1ns/1ps
module axi_host (
    axi_bus bus
);
    initial begin
        bus.awaddr  = 32'h0000_0000;
        bus.awvalid = 1'b0;
        bus.wdata   = 32'h0000_0000;
        bus.wstrb   = 4'h0;
        bus.wvalid  = 1'b0;
        bus.bready  = 1'b0;
        bus.araddr  = 32'h0000_0000;
        bus.arvalid = 1'b0;
        bus.rready  = 1'b0;
    end

    task automatic write(input logic [31:0] addr, input logic [31:0] data,
                         output logic [1:0] resp);
        @(posedge bus.clk);
        bus.awaddr  <= addr;
        bus.awvalid <= 1'b1;
        bus.wdata   <= data;
        bus.wstrb   <= 4'hf;
        bus.wvalid  <= 1'b1;
        bus.bready  <= 1'b1;
        // Each channel let go only after its own acceptance
        do begin
            @(posedge bus.clk);
            #1;
            if (bus.aw_hs) bus.awvalid <= 1'b0;
            if (bus.w_hs) bus.wvalid <= 1'b0;
        end while (!bus.b_hs);
        bus.bready <= 1'b0;
        resp = bus.bresp_q;
    endtask : write

    task automatic read(input logic [31:0] addr, output logic [31:0] data,
                        output logic [1:0] resp);
        @(posedge bus.clk);
        bus.araddr  <= addr;
        bus.arvalid <= 1'b1;
        bus.rready  <= 1'b1;
        do begin
            @(posedge bus.clk);
            #1;
            if (bus.ar_hs) bus.arvalid <= 1'b0;
        end while (!bus.r_hs);
        bus.rready <= 1'b0;
        data = bus.rd_q;
        resp = bus.rresp_q;
    endtask : read
endmodule : axi_host

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench
    import chg_mode_pkg::*;
;
    // Short pulse unit keeps timed phases to a few clocks
    localparam int UNIT = 4;
    logic        clk;
    logic        rst_n;
    sense_s      sense;
    drive_s      drive;
    logic        charger_on;
    logic [1:0]  resp;
    logic [31:0] rd;
    int          n_errors;
    int          check_count;

    axi_bus bus (.clk(clk));
    axi_host host_inst (.bus(bus));
    chg_mode_ctrl #(.UNIT_CLKS(UNIT)) chg_mode_ctrl_inst (
        .clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(bus.awaddr), .s_axi_awvalid(bus.awvalid),
        .s_axi_awready(bus.awready), .s_axi_wdata(bus.wdata),
        .s_axi_wstrb(bus.wstrb), .s_axi_wvalid(bus.wvalid),
        .s_axi_wready(bus.wready), .s_axi_bresp(bus.bresp),
        .s_axi_bvalid(bus.bvalid), .s_axi_bready(bus.bready),
        .s_axi_araddr(bus.araddr), .s_axi_arvalid(bus.arvalid),
        .s_axi_arready(bus.arready), .s_axi_rdata(bus.rdata),
        .s_axi_rresp(bus.rresp), .s_axi_rvalid(bus.rvalid),
        .s_axi_rready(bus.rready), .sense(sense), .drive(drive),
        .charger_on(charger_on)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        sense <= sense_s'(8'h05);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : do_reset

    // Sense pins pass two flops before the mode logic sees them
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask : settle

    task automatic strobe();
        @(posedge clk);
        sense.meas_strobe <= 1'b1;
        @(posedge clk);
        sense.meas_strobe <= 1'b0;
        settle();
    endtask : strobe

    task automatic t_regs();
        do_reset();
        host_inst.read(ADDR_CTRL, rd, resp);
        check(rd, 32'h0000_0000); // auto termination off
        host_inst.read(ADDR_STATUS, rd, resp);
        check(rd, 32'h0000_0000);
        host_inst.write(ADDR_TIMING, 32'h0000_003f, resp);
        check({30'h0, resp}, {30'h0, RESP_OKAY});
        host_inst.read(ADDR_TIMING, rd, resp);
        check(rd, 32'h0000_003f);
        host_inst.write(ADDR_STATUS, 32'h0000_000f, resp);
        host_inst.read(ADDR_STATUS, rd, resp);
        check(rd, 32'h0000_0000);
        host_inst.read(32'h0000_000c, rd, resp);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        check(rd, 32'h0000_0000);
        host_inst.write(32'h0000_0010, 32'h0000_0001, resp);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
    endtask : t_regs

    task automatic t_fast();
        do_reset();
        host_inst.write(ADDR_CTRL, 32'h0000_0003, resp);
        settle();
        host_inst.read(ADDR_STATUS, rd, resp);
        check(rd, 32'h0000_0001); // active flag
        check(32'({drive.full_on, drive.regulate_cc, charger_on}), 32'h5);
        sense.over_ovlo <= 1'b1;
        settle();
        check(32'(charger_on), 32'h0); // lockout
        sense.over_ovlo <= 1'b0;
        settle();
        check(32'(charger_on), 32'h1); // released
    endtask : t_fast

    task automatic t_voltage(input logic auto_term);
        do_reset();
        host_inst.write(ADDR_CTRL, {26'h0, auto_term, 5'h09}, resp);
        settle();
        sense.over_term <= 1'b1;
        settle();
        sense.over_term <= 1'b0;
        host_inst.read(ADDR_STATUS, rd, resp);
        check(32'(rd[3:1]), 32'h1); // voltage phase
        check(32'({drive.regulate_v, drive.v_target}), 32'h5);
        sense.i_le_term <= 1'b1;
        strobe();
        host_inst.read(ADDR_STATUS, rd, resp);
        check(32'(rd[3:1]), auto_term ? 32'h5 : 32'h1);
        check(32'(charger_on), 32'(!auto_term)); // charging stops only with auto termination
        if (auto_term) begin
            sense.i_le_term <= 1'b0;
            sense.below_resume <= 1'b1;
            strobe();
            host_inst.read(ADDR_STATUS, rd, resp);
            check(32'(rd[3]), 32'h1); // still debouncing
            strobe();
            host_inst.read(ADDR_STATUS, rd, resp);
            check(32'(rd[3:1]), 32'h1); // resumed
            check(32'(charger_on), 32'h1); // regulation back
        end
    endtask : t_voltage

    task automatic t_pulse();
        do_reset();
        host_inst.write(ADDR_TIMING, 32'h0000_0030, resp);
        host_inst.write(ADDR_CTRL, 32'h0000_0025, resp);
        settle();
        sense.over_term <= 1'b1;
        settle();
        host_inst.read(ADDR_STATUS, rd, resp);
        check(32'(rd[3:1]), 32'h1); // no termination
        check(32'(charger_on), 32'h0); // off above threshold
        sense.over_term <= 1'b0;
        repeat (UNIT + 6) @(posedge clk);
        check(32'({charger_on, drive.regulate_cc, drive.full_on}), 32'h6);
        sense.over_term <= 1'b1;
        host_inst.write(ADDR_TIMING, 32'h0000_0000, resp);
        repeat (10 * UNIT) @(posedge clk);
        host_inst.read(ADDR_STATUS, rd, resp);
        check(32'(rd[3]), 32'h1); // long off ends charge
    endtask : t_pulse

    task automatic t_presence(input logic pd_dis);
        do_reset();
        host_inst.write(ADDR_CTRL, {25'h0, pd_dis, 6'h01}, resp);
        settle();
        sense.i_sensed <= 1'b0;
        strobe();
        host_inst.read(ADDR_STATUS, rd, resp);
        check(32'(rd[2]), 32'(!pd_dis)); // absent flag
        if (!pd_dis) check(32'(rd[1]), 32'h1); // phase flag
        check(32'(drive.regulate_v), 32'(!pd_dis));
        sense.i_sensed <= 1'b1;
        strobe();
        host_inst.read(ADDR_STATUS, rd, resp);
        check(32'(rd[2:1]), 32'h0); // current seen again
    endtask : t_presence

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        rst_n = 1'b0;
        sense = sense_s'(8'h05);
        n_errors = 0;
        check_count = 0;
        t_regs();
        t_fast();
        t_voltage(1'b0);
        t_voltage(1'b1);
        t_pulse();
        t_presence(1'b0);
        t_presence(1'b1);
        results();
    end

    // Whole run is a few hundred clocks; this cuts a hang short
    initial begin
        #200000;
        n_errors++;
        results();
    end
endmodule : testbench
